//--- hdl/two_wire_defines.svh
// Purpose: offsets, field positions, reset values and status codes of the two-wire master
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   status codes keep the low three bits zero
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH

// register byte offsets
`define OFS_CTRL    8'h00
`define OFS_STATUS  8'h04
`define OFS_DATA    8'h08
`define OFS_BITRATE 8'h0C

// control register bit positions
`define CB_FLAG     7
`define CB_ACKEN    6
`define CB_START    5
`define CB_STOP     4
`define CB_WCOL     3
`define CB_EN       2
`define CB_IE       0

// reset values
`define BITRATE_RST 8'h0A
`define DATA_RST    8'hFF

// status codes
`define STAT_START  8'h08
`define STAT_RSTART 8'h10
`define STAT_AW_ACK 8'h18
`define STAT_AW_NAK 8'h20
`define STAT_DT_ACK 8'h28
`define STAT_DT_NAK 8'h30
`define STAT_LOST   8'h38
`define STAT_AR_ACK 8'h40
`define STAT_AR_NAK 8'h48
`define STAT_DR_ACK 8'h50
`define STAT_DR_NAK 8'h58
`define STAT_IDLE   8'hF8

`endif

//--- hdl/two_wire_pkg.sv
// Purpose: types shared by the two-wire master
// Assumes: nothing
// Notes:   sequencer states only
package two_wire_pkg;
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_START  = 3'b001,
        S_RSTART = 3'b010,
        S_BIT    = 3'b011,
        S_ACK    = 3'b100,
        S_HOLD   = 3'b101,
        S_STOP   = 3'b110
    } seq_state_t;
endpackage

//--- hdl/two_wire_sync.sv
// Purpose: two-flop synchronisers for the bus lines
// Assumes: inputs are asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module two_wire_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,    // system clock
    input  wire logic         rst_n,  // async reset, active low
    input  wire logic [W-1:0] din,    // raw pin levels
    output logic      [W-1:0] dout    // synchronised levels
);
    logic [W-1:0] meta_q;

    // one pair of flops per line, idle bus level is high
    for (genvar i = 0; i < W; i++) begin : g_sync
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q[i] <= 1'b1;
                dout[i]   <= 1'b1;
            end else begin
                meta_q[i] <= din[i];
                dout[i]   <= meta_q[i];
            end
        end
    end
endmodule

//--- hdl/two_wire_master.sv
// Purpose: APB-attached byte-level two-wire bus master, transmit and receive
// Assumes: open-drain pins resolved outside; sclIn/sdaIn are asynchronous
// Notes:   one bit takes four quarter periods of (bitrate+1) clocks each; at bitrate 0 or 1 the third waits longer for the synchronised clock
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "two_wire_defines.svh"
module two_wire_master
    import two_wire_pkg::*;
(
    input  wire logic        clk,      // system clock, 10 MHz
    input  wire logic        rst_n,    // async reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB direction, 1 = write
    input  wire logic [7:0]  paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic      [31:0] prdata,   // APB read data, registered
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error on unmapped address
    input  wire logic        sclIn,    // clock line level
    output logic             sclOut,   // clock line drive value, always 0
    output logic             sclOe,    // pull clock line low
    input  wire logic        sdaIn,    // data line level
    output logic             sdaOut,   // data line drive value, always 0
    output logic             sdaOe,    // pull data line low
    output logic             irq       // interrupt request, active high
);
    // control, data, bit rate and status register fields
    logic       flag_q;
    logic       ackEn_q;
    logic       startReq_q;
    logic       stopReq_q;
    logic       wcol_q;
    logic       enable_q;
    logic       intEn_q;
    logic [7:0] data_q;
    logic [7:0] bitRate_q;
    logic [7:0] status_q;

    // bus side
    logic [1:0] lineS;
    logic       sclS;
    logic       sdaS;
    logic       sclPrev_q;
    logic       sdaPrev_q;
    logic       busy_q;
    logic [7:0] divCnt_q;
    logic       tick;

    // sequencer
    seq_state_t state_q;
    logic [1:0] ph_q;
    logic [2:0] bitCnt_q;
    logic [7:0] shReg_q;
    logic       tx_q;
    logic       isAddr_q;
    logic       rxMode_q;
    logic       rep_q;
    logic       ackOut_q;
    logic       sclOe_q;
    logic       sdaOe_q;
    logic       setFlag_q;
    logic       stopDone_q;
    logic       rxLoad_q;

    // APB
    logic       accQ_q;
    logic       access;
    logic       wrEn;
    logic       hitCtrl;
    logic       hitStat;
    logic       hitData;
    logic       hitRate;
    logic       mapped;
    logic [7:0] rdByte;

    // pin synchronisers
    two_wire_sync #(.W(2)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({sclIn, sdaIn}),
        .dout  (lineS)
    );
    assign sclS = lineS[1];
    assign sdaS = lineS[0];

    // open-drain pins only ever pull low
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe  = sclOe_q;
    assign sdaOe  = sdaOe_q;
    assign irq    = flag_q & intEn_q;

    // address decode
    always_comb begin
        hitCtrl = 1'b0;
        hitStat = 1'b0;
        hitData = 1'b0;
        hitRate = 1'b0;
        if (paddr == `OFS_CTRL) begin
            hitCtrl = 1'b1;
        end else if (paddr == `OFS_STATUS) begin
            hitStat = 1'b1;
        end else if (paddr == `OFS_DATA) begin
            hitData = 1'b1;
        end else if (paddr == `OFS_BITRATE) begin
            hitRate = 1'b1;
        end
    end
    assign mapped = hitCtrl | hitStat | hitData | hitRate;

    // read mux, status low three bits read zero
    always_comb begin
        rdByte = 8'h00;
        if (hitCtrl) begin
            rdByte = {flag_q, ackEn_q, startReq_q, stopReq_q, wcol_q, enable_q, 1'b0, intEn_q};
        end else if (hitStat) begin
            rdByte = {status_q[7:3], 3'b000};
        end else if (hitData) begin
            rdByte = data_q;
        end else if (hitRate) begin
            rdByte = bitRate_q;
        end
    end

    // one wait state per access; read data captured in the first access cycle, writes in the second
    assign access  = psel & penable;
    assign pready  = accQ_q;
    assign pslverr = accQ_q & ~mapped;
    assign wrEn    = accQ_q & access & pwrite;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accQ_q <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            accQ_q <= access & ~accQ_q;
            if (access & ~accQ_q & ~pwrite) begin
                prdata <= {24'h00_0000, rdByte};
            end
        end
    end

    // control register; hardware set of flag wins over software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q     <= 1'b0;
            ackEn_q    <= 1'b0;
            startReq_q <= 1'b0;
            stopReq_q  <= 1'b0;
            enable_q   <= 1'b0;
            intEn_q    <= 1'b0;
        end else begin
            if (wrEn & hitCtrl) begin
                ackEn_q    <= pwdata[`CB_ACKEN];
                startReq_q <= pwdata[`CB_START];
                stopReq_q  <= pwdata[`CB_STOP];
                enable_q   <= pwdata[`CB_EN];
                intEn_q    <= pwdata[`CB_IE];
                if (pwdata[`CB_FLAG]) begin
                    flag_q <= 1'b0;
                end
            end
            if (stopDone_q) begin
                stopReq_q <= 1'b0;
            end
            if (setFlag_q) begin
                flag_q <= 1'b1;
            end
        end
    end

    // write collision: set by a data write with flag low, cleared by a good one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wcol_q <= 1'b0;
        end else if (wrEn & hitData) begin
            wcol_q <= ~flag_q;
        end
    end

    // data register: software loads only while flag set, receiver deposits bytes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= `DATA_RST;
        end else if (rxLoad_q) begin
            data_q <= shReg_q;
        end else if (wrEn & hitData & flag_q) begin
            data_q <= pwdata[7:0];
        end
    end

    // bit rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitRate_q <= `BITRATE_RST;
        end else if (wrEn & hitRate) begin
            bitRate_q <= pwdata[7:0];
        end
    end

    // quarter-bit tick generator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= 8'h00;
        end else if (tick) begin
            divCnt_q <= 8'h00;
        end else begin
            divCnt_q <= divCnt_q + 8'h01;
        end
    end
    assign tick = (divCnt_q == bitRate_q);

    // bus busy tracking from START and STOP seen on the lines
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            busy_q    <= 1'b0;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
            if (sclS & sclPrev_q & sdaPrev_q & ~sdaS) begin
                busy_q <= 1'b1;
            end else if (sclS & sclPrev_q & ~sdaPrev_q & sdaS) begin
                busy_q <= 1'b0;
            end
        end
    end

    // sequencer: START, bits, ack slot, hold, STOP
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= S_IDLE;
            ph_q       <= 2'd0;
            bitCnt_q   <= 3'd0;
            shReg_q    <= 8'h00;
            tx_q       <= 1'b0;
            isAddr_q   <= 1'b0;
            rxMode_q   <= 1'b0;
            rep_q      <= 1'b0;
            ackOut_q   <= 1'b0;
            sclOe_q    <= 1'b0;
            sdaOe_q    <= 1'b0;
            status_q   <= `STAT_IDLE;
            setFlag_q  <= 1'b0;
            stopDone_q <= 1'b0;
            rxLoad_q   <= 1'b0;
        end else begin
            setFlag_q  <= 1'b0;
            stopDone_q <= 1'b0;
            rxLoad_q   <= 1'b0;
            if (!enable_q) begin
                state_q <= S_IDLE;
                sclOe_q <= 1'b0;
                sdaOe_q <= 1'b0;
            end else begin
                case (state_q)
                S_IDLE: begin
                    sclOe_q <= 1'b0;
                    sdaOe_q <= 1'b0;
                    // wait for a free bus before START
                    if (tick & startReq_q & ~flag_q & ~setFlag_q
                        & ~busy_q & sclS & sdaS) begin
                        state_q <= S_START;
                        ph_q    <= 2'd0;
                        rep_q   <= 1'b0;
                    end
                end
                S_START: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'd1;
                        if (ph_q == 2'd0) begin
                            sdaOe_q <= 1'b1;  // data falls with clock high
                        end else if (ph_q == 2'd2) begin
                            sclOe_q <= 1'b1;
                        end else if (ph_q == 2'd3) begin
                            status_q  <= rep_q ? `STAT_RSTART : `STAT_START;
                            setFlag_q <= 1'b1;
                            isAddr_q  <= 1'b1;
                            rxMode_q  <= 1'b0;
                            state_q   <= S_HOLD;
                            ph_q      <= 2'd0;
                        end
                    end
                end
                S_RSTART: begin
                    // release data, then clock, keeping ownership of the bus
                    if (tick & ~(ph_q == 2'd2 & ~sclS)) begin
                        ph_q <= ph_q + 2'd1;
                        if (ph_q == 2'd0) begin
                            sdaOe_q <= 1'b0;
                        end else if (ph_q == 2'd1) begin
                            sclOe_q <= 1'b0;
                        end else if (ph_q == 2'd3) begin
                            state_q <= S_START;
                            ph_q    <= 2'd0;
                            rep_q   <= 1'b1;
                        end
                    end
                end
                S_HOLD: begin
                    sclOe_q <= 1'b1;
                    sdaOe_q <= 1'b0;
                    if (ph_q == 2'd0) begin
                        ph_q <= 2'd1;  // lets the flag settle
                    end else if (!flag_q) begin
                        ph_q <= 2'd0;
                        if (stopReq_q) begin
                            state_q <= S_STOP;
                        end else if (startReq_q) begin
                            state_q <= S_RSTART;
                        end else begin
                            state_q  <= S_BIT;
                            bitCnt_q <= 3'd0;
                            tx_q     <= isAddr_q | ~rxMode_q;
                            shReg_q  <= (isAddr_q | ~rxMode_q) ? data_q : 8'h00;
                        end
                    end
                end
                S_BIT: begin
                    // ph0 set data, ph1 clock high, ph2 sample, ph3 clock low
                    if (tick & ~(ph_q == 2'd2 & ~sclS)) begin
                        ph_q <= ph_q + 2'd1;
                        if (ph_q == 2'd0) begin
                            sdaOe_q <= tx_q & ~shReg_q[7];
                        end else if (ph_q == 2'd1) begin
                            sclOe_q <= 1'b0;
                        end else if (ph_q == 2'd2) begin
                            if (tx_q & shReg_q[7] & ~sdaS) begin
                                sclOe_q   <= 1'b0;
                                sdaOe_q   <= 1'b0;
                                status_q  <= `STAT_LOST;
                                setFlag_q <= 1'b1;
                                state_q   <= S_IDLE;
                                ph_q      <= 2'd0;
                            end else begin
                                shReg_q <= {shReg_q[6:0], sdaS};
                            end
                        end else begin
                            sclOe_q  <= 1'b1;
                            bitCnt_q <= bitCnt_q + 3'd1;
                            if (bitCnt_q == 3'd7) begin
                                state_q  <= S_ACK;
                                ackOut_q <= ackEn_q;
                                if (isAddr_q) begin
                                    rxMode_q <= shReg_q[0];
                                end
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (tick & ~(ph_q == 2'd2 & ~sclS)) begin
                        ph_q <= ph_q + 2'd1;
                        if (ph_q == 2'd0) begin
                            sdaOe_q <= ~tx_q & ackOut_q;
                        end else if (ph_q == 2'd1) begin
                            sclOe_q <= 1'b0;
                        end else if (ph_q == 2'd2) begin
                            if (~tx_q & ~ackOut_q & ~sdaS) begin
                                sdaOe_q   <= 1'b0;
                                status_q  <= `STAT_LOST;
                                setFlag_q <= 1'b1;
                                state_q   <= S_IDLE;
                                ph_q      <= 2'd0;
                            end else if (isAddr_q) begin
                                status_q <= rxMode_q ? (sdaS ? `STAT_AR_NAK : `STAT_AR_ACK)
                                                     : (sdaS ? `STAT_AW_NAK : `STAT_AW_ACK);
                            end else if (tx_q) begin
                                status_q <= sdaS ? `STAT_DT_NAK : `STAT_DT_ACK;
                            end else begin
                                status_q <= ackOut_q ? `STAT_DR_ACK : `STAT_DR_NAK;
                                rxLoad_q <= 1'b1;
                            end
                        end else begin
                            sclOe_q   <= 1'b1;
                            setFlag_q <= 1'b1;
                            isAddr_q  <= 1'b0;
                            state_q   <= S_HOLD;
                            ph_q      <= 2'd0;
                        end
                    end
                end
                S_STOP: begin
                    // data low, clock high, then data rises with clock high
                    if (tick & ~(ph_q == 2'd2 & ~sclS)) begin
                        ph_q <= ph_q + 2'd1;
                        if (ph_q == 2'd0) begin
                            sdaOe_q <= 1'b1;
                        end else if (ph_q == 2'd1) begin
                            sclOe_q <= 1'b0;
                        end else if (ph_q == 2'd2) begin
                            sdaOe_q <= 1'b0;
                        end else begin
                            stopDone_q <= 1'b1;
                            status_q   <= `STAT_IDLE;
                            state_q    <= S_IDLE;  // start request re-arms START
                            ph_q       <= 2'd0;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
                endcase
            end
        end
    end
endmodule

//--- dv/two_wire_master_asserts.sv
// Purpose: port-level checker for the two-wire master
// Assumes: bench keeps interrupt_enable set except where it tests gating
// Notes:   bound to every two_wire_master instance
`timescale 1ns/1ns
`include "two_wire_defines.svh"
module two_wire_master_asserts (
    input wire logic        clk,     // clock
    input wire logic        rst_n,   // reset, active low
    input wire logic        psel,    // select
    input wire logic        penable, // access
    input wire logic        pwrite,  // direction
    input wire logic [7:0]  paddr,   // address
    input wire logic [31:0] pwdata,  // write data
    input wire logic [31:0] prdata,  // read data
    input wire logic        pready,  // ready
    input wire logic        pslverr, // error
    input wire logic        sclOe,   // clock pull
    input wire logic        sdaOe,   // data pull
    input wire logic        irq      // interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ctlWr;
    // completed control write
    assign ctlWr = pready && psel && penable && pwrite && paddr == `OFS_CTRL;

    a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (pready && paddr > `OFS_BITRATE |-> pslverr)
        else $error("unmapped access without error");
    a_stat_low_zero: assert property (pready && !pwrite && paddr == `OFS_STATUS
        |-> prdata[2:0] == 3'h0) else $error("status low bits not zero");
    a_flag_clears: assert property (ctlWr && pwdata[7] |=> !irq)
        else $error("flag not cleared by writing one");
    a_flag_zero_keeps: assert property (ctlWr && !pwdata[7] && pwdata[0] && irq |=> irq)
        else $error("flag cleared by writing zero");
    a_irq_gated: assert property (ctlWr && !pwdata[0] |=> !irq)
        else $error("interrupt without enable");
    a_hold_scl: assert property (irq && sclOe |=> sclOe || !irq)
        else $error("clock line released while flag set");
    a_frozen_lines: assert property (irq ##1 irq |-> $stable(sdaOe))
        else $error("data line moved while flag set");
    c_flag: cover property ($rose(irq));
    c_err: cover property (pslverr);
    c_release: cover property ($fell(sclOe) && !irq);
endmodule

bind two_wire_master two_wire_master_asserts chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclOe(sclOe), .sdaOe(sdaOe), .irq(irq));

//--- dv/two_wire_slave_model.sv
// Purpose: behavioural slave on the two-wire bus
// Assumes: both lines have pull-ups resolved by the bench
// Notes:   acks its own address and written bytes; sends a counting pattern on reads
`timescale 1ns/1ns
module two_wire_slave_model #(
    parameter logic [6:0] ADDR  = 7'h2A, // address it answers
    parameter logic [7:0] FIRST = 8'h5A  // first byte sent on a read
) (
    input  wire logic       scl,     // clock line level
    input  wire logic       sda,     // data line level
    output logic            sdaPull, // pulls data line low
    output logic [7:0]      lastRx   // last byte written to it
);
    logic [7:0] sh, tx;
    logic       act, first, hit, rd, mAck;
    int         n;
    initial begin
        sdaPull = 1'b0;
        act = 1'b0;
        hit = 1'b0;
        lastRx = 8'h00;
    end
    // framing: data edges while clock is high
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        first = 1'b1;
        n = 0;
    end
    always @(posedge sda) if (scl) begin
        act = 1'b0;
        sdaPull = 1'b0;
    end
    // sample data bits, then the ack bit, on clock rise
    always @(posedge scl) if (act) begin
        if (n < 8) sh = {sh[6:0], sda};
        else mAck = !sda;
        n = n + 1;
    end
    // drive on clock fall; a foreign address gets no ack
    always @(negedge scl) if (act) begin
        if (n == 8) begin
            if (first) begin
                hit = sh[7:1] == ADDR;
                rd = sh[0];
            end else if (hit && !rd) lastRx = sh;
            sdaPull = hit && (first || !rd);
        end else if (n == 9) begin
            n = 0;
            if (hit && rd && (first || mAck)) begin // stop sending after a NOT ACK
                tx = first ? FIRST : tx + 8'h01;
                sdaPull = !tx[7];
            end else begin
                sdaPull = 1'b0;
                hit = hit && !rd;
            end
            first = 1'b0;
        end else if (hit && rd && !first) sdaPull = !tx[7 - n];
    end
endmodule

//--- dv/testbench.sv
// Purpose: self-checking bench for the two-wire master
// Assumes: bitrate 1, so one bus bit takes ten clocks (1000 ns)
// Notes:   bench may pull the data line itself to lose arbitration
`timescale 1ns/1ns
`include "two_wire_defines.svh"
module testbench;
    logic        clk, rst_n, psel, penable, pwrite, tbPull, perr;
    logic [7:0]  paddr, rx;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, irq, slvPull, sclIn, sdaIn;
    int          errors, checks;
    // open-drain lines with pull-ups
    assign sclIn = !sclOe;
    assign sdaIn = !(sdaOe || slvPull || tbPull);
    two_wire_master dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
    two_wire_slave_model slv_u (.scl(sclIn), .sda(sdaIn), .sdaPull(slvPull), .lastRx(rx));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // wait for the flag, then compare the status code
    task automatic flag_stat(input logic [7:0] code);
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (irq !== 1'b1) errors++;
        apb(1'b0, `OFS_STATUS, 8'h00);
        chk(rd, {24'h000000, code});
    endtask
    // wait until the stop request bit drops, then check the lines are free
    task automatic stop_wait();
        int k;
        k = 0;
        do begin
            apb(1'b0, `OFS_CTRL, 8'h00);
            k++;
        end while ((rd & 32'h10) !== 32'h0 && k < 30);
        chk(rd & 32'h10, 32'h0);
        chk({28'h0, sclOut, sdaOut, sclOe, sdaOe}, 32'h0);
    endtask
    task automatic t_reset();
        apb(1'b0, `OFS_STATUS, 8'h00);
        chk(rd, 32'h000000F8);
        apb(1'b0, `OFS_DATA, 8'h00);
        chk(rd, 32'h000000FF);
        apb(1'b1, `OFS_BITRATE, 8'h01);
        apb(1'b0, `OFS_BITRATE, 8'h00);
        chk(rd, 32'h00000001);
        apb(1'b0, 8'h10, 8'h00);
        chk({perr, rd[30:0]}, 32'h80000000);
        $display("t_reset done");
    endtask
    task automatic t_transfer();
        apb(1'b1, `OFS_CTRL, 8'hA5);
        flag_stat(8'h08);
        apb(1'b1, `OFS_DATA, 8'h54);
        apb(1'b1, `OFS_CTRL, 8'h85);
        flag_stat(8'h18);
        apb(1'b1, `OFS_DATA, 8'h3C);
        apb(1'b1, `OFS_CTRL, 8'h85);
        apb(1'b1, `OFS_DATA, 8'h99);
        apb(1'b0, `OFS_CTRL, 8'h00);
        chk(rd & 32'h08, 32'h08);
        flag_stat(8'h28);
        chk({24'h0, rx}, 32'h3C);
        apb(1'b1, `OFS_CTRL, 8'h05);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `OFS_CTRL, 8'h04);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `OFS_CTRL, 8'hA5);
        flag_stat(8'h10);
        apb(1'b1, `OFS_DATA, 8'h55);
        apb(1'b1, `OFS_CTRL, 8'h85);
        flag_stat(8'h40);
        apb(1'b1, `OFS_CTRL, 8'hC5);
        flag_stat(8'h50);
        apb(1'b0, `OFS_DATA, 8'h00);
        chk(rd, 32'h5A);
        apb(1'b1, `OFS_CTRL, 8'h85);
        flag_stat(8'h58);
        apb(1'b0, `OFS_DATA, 8'h00);
        chk(rd, 32'h5B);
        apb(1'b1, `OFS_CTRL, 8'hB5);
        flag_stat(8'h08);
        apb(1'b0, `OFS_CTRL, 8'h00);
        chk(rd & 32'h10, 32'h0);
        apb(1'b1, `OFS_DATA, 8'h43);
        apb(1'b1, `OFS_CTRL, 8'h85);
        flag_stat(8'h48);
        apb(1'b1, `OFS_CTRL, 8'h95);
        stop_wait();
        $display("t_transfer done");
    endtask
    task automatic t_lost();
        apb(1'b1, `OFS_CTRL, 8'hA5);
        flag_stat(8'h08);
        apb(1'b1, `OFS_DATA, 8'h42);
        apb(1'b1, `OFS_CTRL, 8'h85);
        flag_stat(8'h20);
        apb(1'b1, `OFS_DATA, 8'h11);
        apb(1'b1, `OFS_CTRL, 8'h85);
        flag_stat(8'h30);
        apb(1'b1, `OFS_DATA, 8'hFF);
        tbPull <= 1'b1;
        apb(1'b1, `OFS_CTRL, 8'h85);
        flag_stat(8'h38);
        chk({30'h0, sclOe, sdaOe}, 32'h0);
        apb(1'b1, `OFS_CTRL, 8'hA5);
        chk({31'h0, irq}, 32'h0);
        tbPull <= 1'b0;
        flag_stat(8'h08);
        apb(1'b1, `OFS_CTRL, 8'h95);
        stop_wait();
        $display("t_lost done");
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, tbPull} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_transfer();
        t_lost();
        close_out();
    end
    // watchdog
    initial begin
        #2000000;
        errors++;
        close_out();
    end
endmodule
